/* File: design/bsp_ctrl.sv */
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
`include "bsp_map.svh"

module bsp_ctrl
	import bsp_pkg::*;
#(
	parameter int        ADDR_W     = 16,
	parameter bit [15:0] BOOT_START = `BSP_BOOT_RESET
)
(
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic              hready,
	input  wire logic [31:0]       hwdata,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// Core store-program request
	input  wire logic              spm_valid,
	input  wire logic              spm_target_boot,
	input  wire logic              spm_target_rww,
	input  wire logic [3:0]        spm_data,
	// Core load-program request
	input  wire logic              lpm_valid,
	input  wire logic              lpm_target_boot,
	// Core context
	input  wire logic              exec_in_boot,
	input  wire logic              vectors_in_boot,
	input  wire logic              global_irq_en,
	// Flash array and programming interface
	input  wire logic              flash_done,
	input  wire logic              prog_lock_wr,
	input  wire logic [3:0]        prog_lock_data,
	input  wire logic              prog_fuse_wr,
	input  wire logic              prog_fuse_data,
	input  wire logic              chip_erase,
	// Results to core and flash
	output logic                   erase_start,
	output logic                   write_start,
	output logic                   load_start,
	output logic                   lockset_done,
	output logic                   buf_discard,
	output logic                   spm_refused,
	output logic                   lpm_allow,
	output logic                   irq_block,
	output logic                   ready_irq,
	output logic                   rww_busy,
	output logic [ADDR_W-1:0]      reset_vector
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (ADDR_W < 16 || ADDR_W > 32)
	begin : g_bad_width
		$error("ADDR_W must lie between 16 and 32");
	end

	// ----------------------------------------
	// State record
	// ----------------------------------------
	typedef struct packed {
		bsp_state_t        state;     // Sequencer state
		logic [3:0]        cmd;       // Armed command bits 4..1
		logic [2:0]        arm_cnt;   // Cycles left in arm window
		logic              ie;        // Ready interrupt enable
		logic              busy;      // Section busy flag
		logic              buf_full;  // Page buffer holds data
		logic [3:0]        lock;      // Boot lock bits
		logic              fuse;      // Boot vector fuse
		logic              dp_wr;     // Data phase write pending
		logic              dp_ctrl;   // Data phase targets control
		logic [31:0]       rdata;     // Read data
		logic              rdy;       // Bus ready
		logic              erase;     // Erase start pulse
		logic              write;     // Write start pulse
		logic              load;      // Load start pulse
		logic              lset;      // Lock set pulse
		logic              discard;   // Buffer discard pulse
		logic              refused;   // Store refused pulse
		logic              lpm_ok;    // Load permitted
		logic              iblk;      // Interrupt block
		logic              irq;       // Ready interrupt level
		logic [ADDR_W-1:0] rvec;      // Reset vector
	} bsp_st_t;

	bsp_st_t st_r;   // Registered state
	bsp_st_t st_nxt; // Next state

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Write permission: lo bit zero means programmed, blocks
	function automatic logic wr_ok(input logic boot, input logic [3:0] lk);
		wr_ok = boot ? lk[`BSP_LOCK_BOOT_LO] : lk[`BSP_LOCK_APP_LO];
	endfunction

	// Read permission across sections: hi bit zero blocks
	function automatic logic rd_ok(input logic tboot, input logic eboot,
		input logic [3:0] lk);
		rd_ok = 1'b1;
		if (tboot && !eboot)
		begin
			rd_ok = lk[`BSP_LOCK_BOOT_HI];
		end
		else if (!tboot && eboot)
		begin
			rd_ok = lk[`BSP_LOCK_APP_HI];
		end
	endfunction

	// Accepted code check
	function automatic logic code_ok(input bsp_code_t c);
		code_ok = (c == `BSP_CODE_LOAD) || (c == `BSP_CODE_ERASE) ||
			(c == `BSP_CODE_WRITE) || (c == `BSP_CODE_LOCKSET) ||
			(c == `BSP_CODE_REEN);
	endfunction

	// Control register image
	function automatic logic [7:0] ctrl_img(input bsp_st_t s);
		ctrl_img = 8'h00;
		ctrl_img[`BSP_CTRL_IE]   = s.ie;
		ctrl_img[`BSP_CTRL_BUSY] = s.busy;
		ctrl_img[`BSP_CTRL_RES]  = 1'b0;
		ctrl_img[4:1]            = s.cmd;
		ctrl_img[`BSP_CTRL_EN]   = (s.state != BSP_IDLE);
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	bsp_code_t wcode;  // Written lower bits
	logic      spm_go; // Store issued from boot section

	always_comb
	begin
		st_nxt = st_r;
		wcode  = hwdata[4:0];
		spm_go = spm_valid && exec_in_boot;
		// Pulses default low
		st_nxt.erase   = 1'b0;
		st_nxt.write   = 1'b0;
		st_nxt.load    = 1'b0;
		st_nxt.lset    = 1'b0;
		st_nxt.discard = 1'b0;
		st_nxt.refused = 1'b0;
		st_nxt.rdy     = 1'b1;

		// Sequencer
		case (st_r.state)
			BSP_ARMED:
			begin
				if (spm_go)
				begin
					st_nxt.state = BSP_IDLE;
					st_nxt.cmd   = 4'h0;
					if ({st_r.cmd, 1'b1} == `BSP_CODE_LOAD)
					begin
						st_nxt.load     = 1'b1;
						st_nxt.buf_full = 1'b1;
						st_nxt.busy     = 1'b0;
					end
					else if ({st_r.cmd, 1'b1} == `BSP_CODE_LOCKSET)
					begin
						// Bits can only be programmed here
						st_nxt.lock = st_r.lock & spm_data;
						st_nxt.lset = 1'b1;
					end
					else if ({st_r.cmd, 1'b1} == `BSP_CODE_REEN)
					begin
						st_nxt.busy     = 1'b0;
						st_nxt.buf_full = 1'b0;
					end
					else if (wr_ok(spm_target_boot, st_r.lock))
					begin
						st_nxt.state = BSP_BUSY;
						st_nxt.cmd   = st_r.cmd;
						st_nxt.erase = ({st_r.cmd, 1'b1} == `BSP_CODE_ERASE);
						st_nxt.write = ({st_r.cmd, 1'b1} == `BSP_CODE_WRITE);
						if (spm_target_rww)
						begin
							st_nxt.busy = 1'b1;
						end
					end
					else
					begin
						st_nxt.refused = 1'b1;
					end
				end
				else if (st_r.arm_cnt == 3'h1)
				begin
					st_nxt.state = BSP_IDLE;
					st_nxt.cmd   = 4'h0;
				end
				else
				begin
					st_nxt.arm_cnt = st_r.arm_cnt - 3'h1;
				end
			end
			BSP_BUSY:
			begin
				// Enable stays high until the array finishes
				if (flash_done)
				begin
					st_nxt.state = BSP_IDLE;
					if (st_r.cmd == `BSP_CODE_WRITE >> 1)
					begin
						st_nxt.buf_full = 1'b0;
					end
					st_nxt.cmd = 4'h0;
				end
			end
			default:
			begin
				st_nxt.state = BSP_IDLE;
			end
		endcase

		// Bus data phase write
		if (st_r.dp_wr && st_r.dp_ctrl)
		begin
			st_nxt.ie = hwdata[`BSP_CTRL_IE];
			// Commands only while idle; re-enable refused when busy
			if (st_r.state == BSP_IDLE && code_ok(wcode))
			begin
				st_nxt.state   = BSP_ARMED;
				st_nxt.cmd     = wcode[4:1];
				st_nxt.arm_cnt = `BSP_ARM_CYCLES;
				if (wcode == `BSP_CODE_REEN && st_r.buf_full)
				begin
					st_nxt.buf_full = 1'b0;
					st_nxt.discard  = 1'b1;
				end
			end
		end

		// Programming interface: locks and fuse
		if (chip_erase)
		begin
			st_nxt.lock = `BSP_LOCK_RST;
		end
		else if (prog_lock_wr)
		begin
			st_nxt.lock = st_nxt.lock & prog_lock_data;
		end
		if (prog_fuse_wr)
		begin
			st_nxt.fuse = prog_fuse_data;
		end

		// Bus address phase
		st_nxt.dp_wr   = 1'b0;
		st_nxt.dp_ctrl = 1'b0;
		st_nxt.rdata   = 32'h0000_0000;
		if (hsel && hready && htrans[1])
		begin
			st_nxt.dp_wr   = hwrite;
			st_nxt.dp_ctrl = (haddr == `BSP_OFF_CTRL);
			if (!hwrite && haddr == `BSP_OFF_CTRL)
			begin
				st_nxt.rdata = {24'h00_0000, ctrl_img(st_r)};
			end
			else if (!hwrite && haddr == `BSP_OFF_LOCK)
			begin
				st_nxt.rdata = {27'h000_0000, st_r.fuse, st_r.lock};
			end
		end

		// Core-facing results
		st_nxt.lpm_ok = lpm_valid && rd_ok(lpm_target_boot, exec_in_boot, st_r.lock);
		st_nxt.iblk   = (vectors_in_boot && !exec_in_boot && !st_r.lock[`BSP_LOCK_APP_HI]) ||
			(!vectors_in_boot && exec_in_boot && !st_r.lock[`BSP_LOCK_BOOT_HI]);
		st_nxt.irq    = st_r.ie && global_irq_en && (st_r.state == BSP_IDLE);
		st_nxt.rvec   = st_r.fuse ? ADDR_W'(`BSP_APP_RESET) : ADDR_W'(BOOT_START);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r       <= '0;
			st_r.state <= BSP_IDLE;
			st_r.lock  <= `BSP_LOCK_RST;
			st_r.fuse  <= `BSP_FUSE_RST;
			st_r.rvec  <= ADDR_W'(`BSP_APP_RESET);
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign hrdata       = st_r.rdata;
	assign hreadyout    = st_r.rdy;
	assign hresp        = 1'b0;
	assign erase_start  = st_r.erase;
	assign write_start  = st_r.write;
	assign load_start   = st_r.load;
	assign lockset_done = st_r.lset;
	assign buf_discard  = st_r.discard;
	assign spm_refused  = st_r.refused;
	assign lpm_allow    = st_r.lpm_ok;
	assign irq_block    = st_r.iblk;
	assign ready_irq    = st_r.irq;
	assign rww_busy     = st_r.busy;
	assign reset_vector = st_r.rvec;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	reserved_bit_a: assert property (
		st_r.dp_ctrl |-> hrdata[`BSP_CTRL_RES] == 1'b0)
		else $error("reserved control bit read as one");

	arm_window_a: assert property (
		$rose(st_r.state == BSP_ARMED) |-> ##[1:4] (st_r.state != BSP_ARMED))
		else $error("arm window longer than four cycles");

	ready_level_a: assert property (
		(st_r.ie && global_irq_en && st_r.state == BSP_IDLE) |=> ready_irq)
		else $error("ready interrupt not raised while idle");

	ready_gate_a: assert property (
		ready_irq |-> $past(st_r.ie) && $past(global_irq_en))
		else $error("ready interrupt without enables");

	busy_set_a: assert property (
		(st_r.state == BSP_ARMED && spm_go && spm_target_rww &&
		(st_r.cmd == 4'h1 || st_r.cmd == 4'h2) && wr_ok(spm_target_boot, st_r.lock))
		|=> rww_busy && st_r.state == BSP_BUSY)
		else $error("section busy not set on erase or write");

	load_clears_a: assert property (
		load_start |-> !rww_busy)
		else $error("page load left busy flag set");

	lock_one_way_a: assert property (
		!$past(chip_erase) |-> (st_r.lock & ~$past(st_r.lock)) == 4'h0)
		else $error("lock bit unprogrammed without chip erase");

	fuse_hold_a: assert property (
		!prog_fuse_wr |=> $stable(st_r.fuse))
		else $error("fuse changed outside programming interface");

	write_block_a: assert property (
		(st_r.state == BSP_ARMED && spm_go && (st_r.cmd == 4'h1 || st_r.cmd == 4'h2) &&
		!wr_ok(spm_target_boot, st_r.lock)) |=> spm_refused && !erase_start && !write_start)
		else $error("locked section started an operation");

	reen_refused_a: assert property (
		(st_r.state == BSP_BUSY && !flash_done) |=> st_r.state == BSP_BUSY)
		else $error("command accepted during operation");

endmodule

/* File: shared/bsp_map.svh */
// Summary of operation
// - Two lock sets; program only, chip erase restores
// - General write lock never gates store-program
// - General read/write lock never gates load/store
// - Lock bit one unprogrammed, zero programmed
// - Application pair 11 free, 10 blocks writes
// - Application 0x blocks boot reads, masks interrupts
// - Boot pair 11 free, 10 blocks writes
// - Boot 0x blocks application reads, masks interrupts
// - Boot fuse selects application or boot reset
// - Fuse changed only by programming interface
// - Control bit five reserved, reads zero
// - Ready interrupt needs enable and global flag
// - Ready interrupt is a level while idle
// - Section erase/write sets busy, blocks section
// - Re-enable command after completion clears busy
// - Page buffer load clears busy flag
// - Re-enable with enable arms next store
// - Re-enable refused while operation in progress
// - Re-enable during loading discards buffer data
// - Enable arms store four cycles, then clears
// - Only five lower-bit codes are accepted
`ifndef BSP_MAP_SVH
`define BSP_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define BSP_OFF_CTRL      32'h0000_0000
`define BSP_OFF_LOCK      32'h0000_0004

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define BSP_CTRL_IE       7
`define BSP_CTRL_BUSY     6
`define BSP_CTRL_RES      5
`define BSP_CTRL_REEN     4
`define BSP_CTRL_EN       0
`define BSP_CTRL_RST      8'h00

// ----------------------------------------
// Lower five bit command codes
// ----------------------------------------
`define BSP_CODE_LOAD     5'h01
`define BSP_CODE_ERASE    5'h03
`define BSP_CODE_WRITE    5'h05
`define BSP_CODE_LOCKSET  5'h09
`define BSP_CODE_REEN     5'h11

// ----------------------------------------
// Lock and fuse layout, reset values
// ----------------------------------------
`define BSP_LOCK_APP_LO   0
`define BSP_LOCK_APP_HI   1
`define BSP_LOCK_BOOT_LO  2
`define BSP_LOCK_BOOT_HI  3
`define BSP_LOCK_FUSE     4
`define BSP_LOCK_RST      4'hF
`define BSP_FUSE_RST      1'b1

// ----------------------------------------
// Timing and addresses
// ----------------------------------------
`define BSP_ARM_CYCLES    3'h4
`define BSP_APP_RESET     16'h0000
`define BSP_BOOT_RESET    16'h0C00

`endif

/* File: shared/bsp_pkg.sv */
package bsp_pkg;

	// Sequencer state, one-hot
	typedef enum logic [2:0]
	{
		BSP_IDLE  = 3'b001,
		BSP_ARMED = 3'b010,
		BSP_BUSY  = 3'b100
	} bsp_state_t;

	// Lower five control bits as written
	typedef logic [4:0] bsp_code_t;

endpackage

/* File: tb/bsp_core_model.sv */
`timescale 1ns/10ps
// ------------------------------
// Core and flash array model
// ------------------------------
module bsp_core_model
(
	// Clock
	input  wire logic       hclk,
	// Core requests and context
	output logic            spm_valid,
	output logic            spm_target_boot,
	output logic            spm_target_rww,
	output logic [3:0]      spm_data,
	output logic            lpm_valid,
	output logic            lpm_target_boot,
	output logic            exec_in_boot,
	input  wire logic       lpm_allow,
	// Flash array
	input  wire logic       op_start,
	output logic            flash_done
);
	int lat = 4; // Array busy cycles, prompt or slow
	int cnt = 0; // Cycles left in current operation
	initial
	begin
		{spm_valid, spm_target_boot, spm_target_rww, spm_data} = '0;
		{lpm_valid, lpm_target_boot, flash_done} = '0;
		exec_in_boot = 1'b1;
	end
	// Array ends each erase or write after lat cycles
	always @(posedge hclk)
	begin
		cnt <= op_start ? lat : (cnt > 0 ? cnt - 1 : 0);
		flash_done <= (cnt == 1);
	end
	// Store request after w idle cycles, held one cycle
	task automatic store_program_instr(input logic b, r, input logic [3:0] d, input int w);
		repeat (w) @(posedge hclk);
		spm_valid <= 1'b1;
		spm_target_boot <= b;
		spm_target_rww <= r;
		spm_data <= d;
		@(posedge hclk);
		spm_valid <= 1'b0;
	endtask
	// Load request from section e, returns permission
	task automatic lpm(input logic e, t, output logic a);
		exec_in_boot <= e;
		lpm_valid <= 1'b1;
		lpm_target_boot <= t;
		@(posedge hclk);
		lpm_valid <= 1'b0;
		#1 a = lpm_allow;
	endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	import bsp_pkg::*;
	// ------------------------------
	// Signals
	// ------------------------------
	logic        hclk, hresetn, hwrite, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic        vectors_in_boot, global_irq_en, chip_erase;
	logic        prog_lock_wr, prog_fuse_wr, prog_fuse_data;
	logic [3:0]  prog_lock_data, spm_data;
	logic        spm_valid, spm_target_boot, spm_target_rww;
	logic        lpm_valid, lpm_target_boot, exec_in_boot, flash_done;
	logic        erase_start, write_start, load_start, lockset_done;
	logic        buf_discard, spm_refused, lpm_allow, irq_block, ready_irq, rww_busy;
	logic [15:0] reset_vector;
	logic [5:0]  pulses; // Command result pulses
	logic        rd_ph = 1'b0; // Read data phase pending
	logic        a;      // Load permission seen
	logic [31:0] seed;   // Random state
	logic [31:0] rq[$];  // Expected read data
	logic [5:0]  pq[$];  // Expected pulse sets
	int          errors, n_tests;
	localparam logic [5:0] P_ER = 6'h20, P_WR = 6'h10, P_LD = 6'h08;
	localparam logic [5:0] P_LK = 6'h04, P_DI = 6'h02, P_RF = 6'h01;
	assign pulses = {erase_start, write_start, load_start, lockset_done, buf_discard, spm_refused};
	bsp_ctrl DUT
	(
		.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
		.spm_valid, .spm_target_boot, .spm_target_rww, .spm_data, .lpm_valid,
		.lpm_target_boot, .exec_in_boot, .vectors_in_boot, .global_irq_en,
		.flash_done, .prog_lock_wr, .prog_lock_data, .prog_fuse_wr, .prog_fuse_data,
		.chip_erase, .erase_start, .write_start, .load_start, .lockset_done,
		.buf_discard, .spm_refused, .lpm_allow, .irq_block, .ready_irq, .rww_busy,
		.reset_vector
	);
	bsp_core_model u_core
	(
		.hclk, .spm_valid, .spm_target_boot, .spm_target_rww, .spm_data, .lpm_valid,
		.lpm_target_boot, .exec_in_boot, .lpm_allow, .op_start(erase_start | write_start),
		.flash_done
	);
	// ------------------------------
	// Helpers
	// ------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] g, e);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One single transfer; read data noted for the monitor
	task automatic bus(input logic w, input logic [31:0] ad, d);
		htrans <= 2'b10;
		haddr <= ad;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		if (!w)
			rq.push_back(d);
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		#1;
	endtask
	// Control write, then a store w cycles later
	task automatic cmd(input logic [7:0] c, input logic b, r, input logic [3:0] d,
		input int w, input logic [5:0] p);
		if (p != 0)
			pq.push_back(p);
		bus(1, 32'h0, {24'h0, c});
		u_core.store_program_instr(b, r, d, w);
		repeat (2) @(posedge hclk);
		#1;
	endtask
	// Wait for the array to finish, bounded
	task automatic wait_done;
		int i;
		for (i = 0; i < 300; i++)
		begin
			@(posedge hclk);
			if (flash_done === 1'b1)
				break;
		end
		if (i == 300)
			chk(32'h0, 32'h1);
		repeat (2) @(posedge hclk);
		#1;
	endtask
	// Programming interface pulse: 0 lock, 1 fuse, 2 chip erase
	task automatic prog(input int k, input logic [3:0] d);
		prog_lock_data <= d;
		prog_fuse_data <= d[0];
		prog_lock_wr <= (k == 0);
		prog_fuse_wr <= (k == 1);
		chip_erase <= (k == 2);
		@(posedge hclk);
		{prog_lock_wr, prog_fuse_wr, chip_erase} <= 3'h0;
		repeat (2) @(posedge hclk);
		#1;
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ------------------------------
	// Clock, watchdog, monitor
	// ------------------------------
	initial
	begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	initial
	begin
		#400_000;
		errors++;
		final_report;
	end
	// Results compared against the oldest note
	always @(posedge hclk)
	begin
		if (rd_ph && hreadyout)
			chk(hrdata, rq.size() ? rq.pop_front() : 32'hdead_beef);
		if (hreadyout === 1'b1)
			rd_ph <= htrans[1] && !hwrite;
		if (hresetn === 1'b1 && pulses !== 6'h00)
			chk(32'(pulses), pq.size() ? 32'(pq.pop_front()) : 32'h0);
	end
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial
	begin
		{hresetn, hwrite, vectors_in_boot, global_irq_en, chip_erase} = '0;
		{prog_lock_wr, prog_fuse_wr, prog_fuse_data, htrans, haddr, hwdata} = '0;
		prog_lock_data = '0;
		seed = 32'h5b19_97e4;
		errors = 0;
		n_tests = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(0, 32'h0, 32'h0);
		bus(0, 32'h4, 32'h1f);
		chk(32'(reset_vector), 32'h0);
		global_irq_en <= 1'b1;
		bus(1, 32'h0, 32'ha7);
		u_core.store_program_instr(0, 0, 4'h0, 0);
		bus(0, 32'h0, 32'h80);
		chk(32'(ready_irq), 32'h1);
		global_irq_en <= 1'b0;
		bus(0, 32'h0, 32'h80);
		chk(32'(ready_irq), 32'h0);
		bus(1, 32'h0, 32'h0);
		bus(1, 32'h8, 32'hff);
		chk(32'(hresp), 32'h0);
		bus(0, 32'h8, 32'h0);
		for (int w = 0; w < 5; w++)
			cmd(8'h01, 0, 0, 4'h0, w, w < 4 ? P_LD : 6'h0);
		bus(0, 32'h0, 32'h0);
		seed = lfsr(seed);
		u_core.lat = 4 + int'(seed[2:0]);
		cmd(8'h03, 0, 1, 4'h0, int'(seed[4:3]), P_ER);
		chk(32'(rww_busy), 32'h1);
		wait_done;
		bus(0, 32'h0, 32'h40);
		pq.push_back(P_DI);
		cmd(8'h11, 0, 0, 4'h0, int'(seed[6:5]), 6'h0);
		chk(32'(rww_busy), 32'h0);
		bus(0, 32'h0, 32'h0);
		u_core.lat = 40;
		cmd(8'h05, 0, 1, 4'h0, 0, P_WR);
		cmd(8'h11, 0, 0, 4'h0, 0, 6'h0);
		chk(32'(rww_busy), 32'h1);
		wait_done;
		cmd(8'h01, 0, 0, 4'h0, 1, P_LD);
		chk(32'(rww_busy), 32'h0);
		cmd(8'h09, 0, 0, 4'hc, 2, P_LK);
		bus(0, 32'h4, 32'h1c);
		cmd(8'h03, 0, 0, 4'h0, 0, P_RF);
		u_core.lpm(1, 0, a);
		chk(32'(a), 32'h0);
		u_core.lpm(0, 1, a);
		chk(32'(a), 32'h1);
		vectors_in_boot <= 1'b1;
		u_core.exec_in_boot <= 1'b0;
		repeat (2) @(posedge hclk);
		#1 chk(32'(irq_block), 32'h1);
		prog(2, 4'h0);
		bus(0, 32'h4, 32'h1f);
		chk(32'(irq_block), 32'h0);
		u_core.exec_in_boot <= 1'b1;
		prog(0, 4'hb);
		cmd(8'h03, 1, 0, 4'h0, 3, P_RF);
		u_core.lpm(0, 1, a);
		chk(32'(a), 32'h1);
		prog(0, 4'h3);
		u_core.lpm(0, 1, a);
		chk(32'(a), 32'h0);
		vectors_in_boot <= 1'b0;
		u_core.exec_in_boot <= 1'b1;
		prog(1, 4'h0);
		chk(32'(irq_block), 32'h1);
		chk(32'(reset_vector), 32'h0c00);
		bus(1, 32'h4, 32'h0);
		bus(0, 32'h4, 32'h03);
		prog(2, 4'h0);
		bus(0, 32'h4, 32'h0f);
		chk(32'(pq.size() + rq.size()), 32'h0);
		final_report;
	end
endmodule
